// ---- shared/switch_map_pkg.sv ----
// Constants and types for the switch input function mapper.
// Assumes a single 40 MHz system clock.
package switch_map_pkg;

  localparam int        NUM_IN        = 8;
  localparam int        NUM_ASG       = 7;
  localparam int        CODE_W        = 4;
  localparam int        DEB_W         = 18;
  localparam int        CLK_KHZ       = 40000;
  // Least stable time before a switch change is believed
  localparam int        DEB_TIME_US   = 5000;
  localparam int        DEB_CYC       = (DEB_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int        RUN_IN        = 0;
  localparam logic [7:0] PIN_RST      = 8'hff;

  typedef logic [CODE_W-1:0] code_t;
  localparam code_t F_NONE      = 4'h0;
  localparam code_t F_JOG       = 4'h1;
  localparam code_t F_SCR_DN    = 4'h2;
  localparam code_t F_SCR_UP    = 4'h3;
  localparam code_t F_SEL01     = 4'h4;
  localparam code_t F_SEL02     = 4'h5;
  localparam code_t F_ADVANCE   = 4'h6;
  localparam code_t F_RETARD    = 4'h7;
  localparam code_t F_LOOP      = 4'h8;
  localparam code_t F_MODE      = 4'h9;
  localparam code_t F_RAMP      = 4'ha;
  localparam code_t F_FSTOP     = 4'hb;
  localparam code_t F_REVERSE   = 4'hc;
  localparam code_t F_MAX       = F_REVERSE;

  typedef code_t [NUM_ASG-1:0] asg_table_t;

  typedef struct packed {
    logic       run;
    logic       jog;
    logic       scroll_dn;
    logic       scroll_up;
    logic [1:0] setpt_sel;
    logic       advance;
    logic       retard;
    logic       open_loop;
    logic [1:0] ol_cfg;
    logic       master;
    logic       ramp_pair;
    logic       fast_stop;
    logic       reverse;
    logic       dir_flip;
  } ctrl_t;

  typedef struct packed {
    logic [NUM_IN-1:0]            sync1;
    logic [NUM_IN-1:0]            sync2;
    logic [NUM_IN-1:0]            deb;
    logic [NUM_IN-1:0][DEB_W-1:0] cnt;
    asg_table_t                   asg;
    logic                         err;
    ctrl_t                        ctrl;
  } st_t;

endpackage : switch_map_pkg

// ---- hdl/switch_input_function_mapper.sv ----
// Switch input synchroniser, debouncer, function assignment and decoder.
// Assumes ground-closing switches on sw_n (low = closed) and a
// configuration source that writes one assignment per pulse.
//
// How it works
// RL1 - Advance active while its input is closed
// RL2 - Retard active while its input is closed
// RL3 - Loop input closed gives open-loop per config
// RL4 - Mode input open follower, closed master
// RL5 - Mode input assigned overrides stored mode variable
// RL6 - Closed jog input overrides master/follower choice
// RL7 - Ramp input open pair 0, closed pair 1
// RL8 - Ramp input assigned overrides stored ramp variable
// RL9 - Fast stop closed ramps down on fast ramp
// RL10 - Fast stop closed disables run/stop until open
// RL11 - Jog/master direction reverses while reverse closed
// RL12 - Follower direction opposes lead while reverse closed
// RL13 - No reverse input means forward or lead direction
// RL14 - Reverse change while running flags through-zero ramp
// RL15 - Input 0 fixed run/stop, 1-7 assignable
// RL16 - Codes 1 to 12 decode to their functions
// RL17 - Code 0 leaves an input unused
// RL18 - Duplicate nonzero code refused, error lit
// RL19 - All eight input states shown for display
// RL20 - Input 0 closed runs, open stops
// RL21 - Codes 4 and 5 form set-point selector
// RL22 - Inputs synchronised and debounced before decoding
module switch_input_function_mapper
  import switch_map_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEB_CYC
)
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [NUM_IN-1:0] sw_n,
  input  wire logic              asg_wr,
  input  wire logic [2:0]        asg_idx,
  input  wire code_t             asg_code,
  input  wire logic              mode_select_var,
  input  wire logic              ramp_pair_select_var,
  input  wire logic [1:0]        open_loop_config_var,
  input  wire logic              fb_running,
  output      ctrl_t             ctrl,
  output      logic [NUM_IN-1:0] sw_status,
  output      asg_table_t        asg_table,
  output      logic              asg_err
);

  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYCLES - 1);

  st_t st;
  st_t next_st;

  always_comb
  begin
    logic [15:0] assigned;
    logic [15:0] active;
    logic        dup;
    logic        fs;
    logic        rev;
    assigned = '0;
    active   = '0;
    dup      = 1'b0;
    fs       = 1'b0;
    rev      = 1'b0;
    next_st  = st;

    // Two-stage synchroniser; the first stage feeds only the second
    next_st.sync1 = sw_n;                                    // [RL22]
    next_st.sync2 = st.sync1;                                // [RL22]

    // A level must hold DEBOUNCE_CYCLES before it is believed
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (~st.sync2[i] == st.deb[i])
        next_st.cnt[i] = '0;
      else if (st.cnt[i] == DEB_LAST)
      begin
        next_st.cnt[i] = '0;
        next_st.deb[i] = ~st.sync2[i];                       // [RL22]
      end
      else
        next_st.cnt[i] = st.cnt[i] + 1'b1;
    end

    // Assignment writes; input 0 has no table entry
    next_st.err = 1'b0;
    if (asg_wr && asg_idx != 3'h0)
    begin
      for (int j = 0; j < NUM_ASG; j++)
        if (j != int'(asg_idx) - 1 && st.asg[j] == asg_code)
          dup = 1'b1;
      if ((asg_code != F_NONE && dup) || asg_code > F_MAX)
        next_st.err = 1'b1;                                  // [RL18]
      else
        next_st.asg[asg_idx - 3'h1] = asg_code;              // [RL15] [RL17]
    end

    // Presence and closed state per function code
    for (int k = 0; k < NUM_ASG; k++)
      if (st.asg[k] != F_NONE)
      begin
        assigned[st.asg[k]] = 1'b1;                          // [RL16]
        active[st.asg[k]]   = st.deb[k + 1];
      end

    fs  = assigned[F_FSTOP] & active[F_FSTOP];
    rev = assigned[F_REVERSE] & active[F_REVERSE];           // [RL13]

    next_st.ctrl.fast_stop = fs;                             // [RL9]
    next_st.ctrl.run       = ~fs & st.deb[RUN_IN];           // [RL10] [RL20]
    next_st.ctrl.jog       = assigned[F_JOG] & active[F_JOG];
    next_st.ctrl.scroll_dn = assigned[F_SCR_DN] & active[F_SCR_DN];
    next_st.ctrl.scroll_up = assigned[F_SCR_UP] & active[F_SCR_UP];
    next_st.ctrl.setpt_sel = {assigned[F_SEL02] & active[F_SEL02],
                              assigned[F_SEL01] & active[F_SEL01]}; // [RL21]
    next_st.ctrl.advance   = assigned[F_ADVANCE] & active[F_ADVANCE]; // [RL1]
    next_st.ctrl.retard    = assigned[F_RETARD] & active[F_RETARD]; // [RL2]
    next_st.ctrl.open_loop = assigned[F_LOOP] & active[F_LOOP]; // [RL3]
    next_st.ctrl.ol_cfg    = (assigned[F_LOOP] & active[F_LOOP]) ?
                             open_loop_config_var : 2'h0;    // [RL3]
    if (assigned[F_JOG] & active[F_JOG])
      next_st.ctrl.master = 1'b0;                            // [RL6]
    else if (assigned[F_MODE])
      next_st.ctrl.master = active[F_MODE];                  // [RL4] [RL5]
    else
      next_st.ctrl.master = mode_select_var;
    next_st.ctrl.ramp_pair = assigned[F_RAMP] ? active[F_RAMP]
                                              : ramp_pair_select_var; // [RL7] [RL8]
    // One flag serves both senses: A lags B, or opposite to lead
    next_st.ctrl.reverse  = rev;                             // [RL11] [RL12]
    next_st.ctrl.dir_flip = (rev != st.ctrl.reverse) & fb_running; // [RL14]
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st       <= '0;
      st.sync1 <= PIN_RST;
      st.sync2 <= PIN_RST;
    end
    else
      st <= next_st;
  end

  assign ctrl      = st.ctrl;
  assign sw_status = st.deb;                                 // [RL19]
  assign asg_table = st.asg;
  assign asg_err   = st.err;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  function automatic logic has_code(asg_table_t t, code_t c);
    logic r;
    r = 1'b0;
    for (int m = 0; m < NUM_ASG; m++)
      if (t[m] == c)
        r = 1'b1;
    return r;
  endfunction : has_code

  function automatic logic code_on(asg_table_t t, logic [7:0] d, code_t c);
    logic r;
    r = 1'b0;
    for (int m = 0; m < NUM_ASG; m++)
      if (t[m] == c)
        r = d[m + 1];
    return r;
  endfunction : code_on

  a_fast_stop_run: assert property ( // [RL10]
    ctrl.fast_stop |-> !ctrl.run)
    else $error("run asserted during fast stop");

  a_run_follow: assert property ( // [RL20]
    !has_code(st.asg, F_FSTOP) |=> ctrl.run == $past(st.deb[RUN_IN]))
    else $error("run does not follow input 0");

  a_dup_refused: assert property ( // [RL18]
    asg_wr && asg_idx != 3'h0 && asg_code != F_NONE &&
    has_code(st.asg, asg_code) &&
    st.asg[asg_idx - 3'h1] != asg_code
    |=> asg_err && $stable(st.asg))
    else $error("duplicate assignment accepted");

  a_valid_taken: assert property ( // [RL15]
    asg_wr && asg_idx != 3'h0 && asg_code <= F_MAX &&
    (asg_code == F_NONE || !has_code(st.asg, asg_code))
    |=> !asg_err && st.asg[$past(asg_idx) - 3'h1] == $past(asg_code))
    else $error("valid assignment not stored");

  a_mode_switch: assert property ( // [RL5]
    has_code(st.asg, F_MODE) && !code_on(st.asg, st.deb, F_JOG)
    |=> ctrl.master == $past(code_on(st.asg, st.deb, F_MODE)))
    else $error("master does not follow mode switch");

  a_jog_over: assert property ( // [RL6]
    code_on(st.asg, st.deb, F_JOG) |=> ctrl.jog && !ctrl.master)
    else $error("jog does not override mode");

  a_ramp_pick: assert property ( // [RL8]
    !has_code(st.asg, F_RAMP) |=> ctrl.ramp_pair == $past(ramp_pair_select_var))
    else $error("ramp pair not from variable");

  a_no_reverse: assert property ( // [RL13]
    !has_code(st.asg, F_REVERSE) |=> !ctrl.reverse)
    else $error("reverse without assignment");

  a_flip_pulse: assert property ( // [RL14]
    ctrl.dir_flip |-> $changed(ctrl.reverse) && $past(fb_running))
    else $error("direction flip without cause");

  a_deb_hold: assert property ( // [RL22]
    $changed(st.deb) |-> $past(st.cnt) != '0)
    else $error("debounced level changed without count");

  a_setpt_sel: assert property ( // [RL21]
    !has_code(st.asg, F_SEL01) && !has_code(st.asg, F_SEL02)
    |=> ctrl.setpt_sel == 2'h0)
    else $error("set-point select without assignment");

  // Level functions follow their debounced inputs one edge later
  a_advance_lvl: assert property ( // [RL1]
    ctrl.advance == $past(code_on(st.asg, st.deb, F_ADVANCE)))
    else $error("advance does not follow its input");

  a_retard_lvl: assert property ( // [RL2]
    ctrl.retard == $past(code_on(st.asg, st.deb, F_RETARD)))
    else $error("retard does not follow its input");

  a_loop_cfg: assert property ( // [RL3]
    code_on(st.asg, st.deb, F_LOOP)
    |=> ctrl.open_loop && ctrl.ol_cfg == $past(open_loop_config_var))
    else $error("open-loop switch not honoured");

  a_loop_closed: assert property ( // [RL3]
    !code_on(st.asg, st.deb, F_LOOP)
    |=> !ctrl.open_loop && ctrl.ol_cfg == 2'h0)
    else $error("closed-loop not kept while loop input open");

  a_mode_stored: assert property ( // [RL5]
    !has_code(st.asg, F_MODE) && !code_on(st.asg, st.deb, F_JOG)
    |=> ctrl.master == $past(mode_select_var))
    else $error("stored mode not used without mode input");

  a_ramp_switch: assert property ( // [RL7]
    has_code(st.asg, F_RAMP)
    |=> ctrl.ramp_pair == $past(code_on(st.asg, st.deb, F_RAMP)))
    else $error("ramp pair does not follow its input");

  a_fast_stop_in: assert property ( // [RL9]
    ctrl.fast_stop == $past(code_on(st.asg, st.deb, F_FSTOP)))
    else $error("fast stop does not follow its input");

  a_fstop_block: assert property ( // [RL10]
    code_on(st.asg, st.deb, F_FSTOP) |=> !ctrl.run)
    else $error("run/stop input acted during fast stop");

  a_run_back: assert property ( // [RL10]
    has_code(st.asg, F_FSTOP) && !code_on(st.asg, st.deb, F_FSTOP)
    |=> ctrl.run == $past(st.deb[RUN_IN]))
    else $error("run/stop not restored after fast stop");

  // Direction
  a_reverse_in: assert property ( // [RL11] [RL12]
    ctrl.reverse == $past(code_on(st.asg, st.deb, F_REVERSE)))
    else $error("reverse does not follow its input");

  a_flip_cause: assert property ( // [RL14]
    $changed(ctrl.reverse) && $past(fb_running) |-> ctrl.dir_flip)
    else $error("direction change while running not flagged");

  a_flip_idle: assert property ( // [RL14]
    !$past(fb_running) |-> !ctrl.dir_flip)
    else $error("direction flip while encoder stopped");

  a_jog_scroll: assert property ( // [RL16]
    {ctrl.jog, ctrl.scroll_dn, ctrl.scroll_up} ==
    $past({code_on(st.asg, st.deb, F_JOG),
           code_on(st.asg, st.deb, F_SCR_DN),
           code_on(st.asg, st.deb, F_SCR_UP)}))
    else $error("jog or scroll does not follow its input");

  a_setpt_pair: assert property ( // [RL21]
    ctrl.setpt_sel == $past({code_on(st.asg, st.deb, F_SEL02),
                             code_on(st.asg, st.deb, F_SEL01)}))
    else $error("set-point selector does not follow its inputs");

  // Assignment port
  a_unassign_ok: assert property ( // [RL17]
    asg_wr && asg_idx != 3'h0 && asg_code == F_NONE
    |=> !asg_err && st.asg[$past(asg_idx) - 3'h1] == F_NONE)
    else $error("code 0 not accepted");

  a_code_range: assert property ( // [RL18]
    asg_wr && asg_idx != 3'h0 && asg_code > F_MAX
    |=> asg_err && $stable(st.asg))
    else $error("out-of-range code accepted");

  a_same_rewrite: assert property ( // [RL18]
    asg_wr && asg_idx != 3'h0 && asg_code <= F_MAX &&
    st.asg[asg_idx - 3'h1] == asg_code
    |=> !asg_err)
    else $error("rewrite of own code refused");

  a_idx_zero: assert property ( // [RL15]
    asg_wr && asg_idx == 3'h0 |=> !asg_err && $stable(st.asg))
    else $error("input 0 took an assignment");

  a_err_cause: assert property ( // [RL15] [RL18]
    !(asg_wr && asg_idx != 3'h0) |=> !asg_err && $stable(st.asg))
    else $error("table or error changed without a write");

  // Per-input debounce and status checks
  for (genvar g = 0; g < NUM_IN; g++)
  begin : g_pin_chk
    a_deb_full: assert property ( // [RL22]
      @(posedge mclk) disable iff (!rst_n)
      $changed(st.deb[g])
      |-> $past(st.cnt[g]) == DEB_LAST &&
          st.deb[g] == !$past(st.sync2[g]))
      else $error("input level taken before it settled");

    a_deb_keep: assert property ( // [RL22]
      @(posedge mclk) disable iff (!rst_n)
      st.deb[g] == !st.sync2[g] |=> $stable(st.deb[g]))
      else $error("debounced level moved while input agreed");

    a_status_bit: assert property ( // [RL19]
      @(posedge mclk) disable iff (!rst_n)
      sw_status[g] == st.deb[g])
      else $error("status does not show input state");
  end

  // Main scenarios

  c_dup_err: cover property (asg_err);
  c_fast_stop: cover property (ctrl.fast_stop ##1 !ctrl.fast_stop);
  c_flip: cover property (ctrl.dir_flip);
  c_setpt3: cover property (ctrl.setpt_sel == 2'h3);
  c_jog_run: cover property (ctrl.jog && ctrl.run);

endmodule : switch_input_function_mapper

// ---- test/switch_bank.sv ----
// Far-side model: eight ground-closing contacts with chatter.
// Assumes pull-ups on the pins, so an open contact reads high.
module switch_bank (
  input  wire logic [7:0] closed,
  output      logic [7:0] sw_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Chatter on every pin, each burst shorter than the debounce span
  initial
  begin
    sw_n = 8'hff;
    forever
    begin
      @(closed);
      repeat (3)
      begin
        sw_n = ~(closed ^ 8'($urandom));
        #20;
      end
      sw_n = ~closed;
    end
  end
endmodule : switch_bank

// ---- test/tb.sv ----
// Self-checking bench for the switch input function mapper.
// Assumes switch_bank on the pins and a debounce span of 4 cycles.
module tb
  import switch_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int kind; logic [31:0] exp;} note_t;
  logic              mclk, rst_n, asg_wr, mode_select_var;
  logic              ramp_pair_select_var, fb_running, asg_err;
  logic [2:0]        asg_idx;
  code_t             asg_code;
  logic [1:0]        open_loop_config_var;
  logic [NUM_IN-1:0] sw_n, sw_status;
  logic [NUM_IN-1:0] closed = '0;
  ctrl_t             ctrl;
  asg_table_t        asg_table, mt;
  int                err_count = 0;
  int                n_compared = 0;
  int                flips = 0;
  note_t             notes[$];
  event              probe;

  switch_bank sw_u (.closed, .sw_n);
  switch_input_function_mapper #(.DEBOUNCE_CYCLES(4)) dut_u (
    .mclk, .rst_n, .sw_n, .asg_wr, .asg_idx, .asg_code, .mode_select_var,
    .ramp_pair_select_var, .open_loop_config_var, .fb_running, .ctrl,
    .sw_status, .asg_table, .asg_err);

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  always @(posedge mclk) if (ctrl.dir_flip === 1'b1) flips++;

  // Expected controls from contact states, table and stored settings
  function automatic ctrl_t ref_ctrl(logic [7:0] c, asg_table_t t,
                                     logic [3:0] v);
    ctrl_t r;
    r = '0;
    r.master = v[0];
    r.ramp_pair = v[1];
    for (int k = 0; k < NUM_ASG; k++)
      case (t[k])
        F_JOG: r.jog = c[k+1];
        F_SCR_DN: r.scroll_dn = c[k+1];
        F_SCR_UP: r.scroll_up = c[k+1];
        F_SEL01: r.setpt_sel[0] = c[k+1];
        F_SEL02: r.setpt_sel[1] = c[k+1];
        F_ADVANCE: r.advance = c[k+1];
        F_RETARD: r.retard = c[k+1];
        F_LOOP: r.open_loop = c[k+1];
        F_MODE: r.master = c[k+1];
        F_RAMP: r.ramp_pair = c[k+1];
        F_FSTOP: r.fast_stop = c[k+1];
        F_REVERSE: r.reverse = c[k+1];
        default: ;
      endcase
    if (r.jog) r.master = 1'b0;
    if (r.open_loop) r.ol_cfg = v[3:2];
    r.run = c[0] & ~r.fast_stop;
    return r;
  endfunction : ref_ctrl

  task automatic note(int kind, logic [31:0] exp);
    notes.push_back('{kind, exp});
  endtask : note

  task automatic tally(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : tally

  task automatic cmp_ctrl(logic [31:0] exp);
    tally("ctrl", exp, 32'(ctrl));
  endtask : cmp_ctrl

  task automatic cmp_status(logic [31:0] exp);
    tally("sw_status", exp, 32'(sw_status));
  endtask : cmp_status

  task automatic cmp_table(logic [31:0] exp);
    tally("asg_table", exp, 32'(asg_table));
  endtask : cmp_table

  task automatic cmp_err(logic [31:0] exp);
    tally("asg_err", exp, 32'(asg_err));
  endtask : cmp_err

  task automatic cmp_flips(logic [31:0] exp);
    tally("dir_flip", exp, 32'(flips));
  endtask : cmp_flips

  always @(probe)
  begin
    note_t n;
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      case (n.kind)
        0: cmp_ctrl(n.exp);
        1: cmp_status(n.exp);
        2: cmp_table(n.exp);
        3: cmp_err(n.exp);
        default: cmp_flips(n.exp);
      endcase
    end
  end

  task automatic apply(logic [7:0] c);
    logic [3:0] v;
    v = 4'($urandom);
    @(posedge mclk);
    closed <= c;
    {open_loop_config_var, ramp_pair_select_var, mode_select_var} <= v;
    repeat (14) @(posedge mclk);
    #1;
    note(0, 32'(ref_ctrl(c, mt, v)));
    note(1, 32'(c));
    -> probe;
  endtask : apply

  task automatic wr(logic [2:0] idx, code_t code, logic bad);
    @(posedge mclk);
    asg_wr <= 1'b1;
    asg_idx <= idx;
    asg_code <= code;
    @(posedge mclk);
    asg_wr <= 1'b0;
    #1;
    if (!bad && idx != 3'd0) mt[idx-1] = code;
    note(2, 32'(mt));
    note(3, 32'(bad));
    -> probe;
  endtask : wr

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial
  begin
    void'($urandom(32'h1caf));
    {rst_n, asg_wr, asg_idx, asg_code, fb_running} = '0;
    {mode_select_var, ramp_pair_select_var, open_loop_config_var} = '0;
    mt = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    for (int k = 0; k < 4; k++) note(k, 32'd0);
    -> probe;
    for (int k = 1; k < 8; k++) wr(3'(k), code_t'(k + 5), 1'b0);
    repeat (24) apply(8'($urandom));
    wr(3'd7, F_ADVANCE, 1'b1);
    wr(3'd2, 4'hd, 1'b1);
    wr(3'd7, F_REVERSE, 1'b0);
    wr(3'd0, F_JOG, 1'b0);
    @(posedge mclk);
    fb_running <= 1'b1;
    apply(closed ^ 8'h80);
    apply(closed ^ 8'h80);
    note(4, 32'd2);
    -> probe;
    @(posedge mclk);
    fb_running <= 1'b0;
    for (int k = 1; k < 8; k++)
      wr(3'(k), code_t'(k < 6 ? k : 0), 1'b0);
    repeat (24) apply(8'($urandom));
    #1;
    close_out();
  end

  initial
  begin
    #(25 * 20000);
    err_count++;
    close_out();
  end
endmodule : tb
